// ===== pkg/lpf_cfg.svh
// Constants for the land pre-pit block framer.
`ifndef LPF_CFG_SVH
`define LPF_CFG_SVH
`define LPF_SYNC_EVEN   3'h7
`define LPF_SYNC_ODD    3'h6
`define LPF_BIT_ONE     3'h5
`define LPF_BIT_ZERO    3'h4
`define LPF_LAST_SYM    4'hc
`define LPF_LAST_FRAME  4'hf
`define LPF_FIRST_FIFO  4'h3
`define LPF_FIRST_ADDR  24'hffcfff
`define LPF_FIFO_DEPTH  8
`define LPF_BYTE_W      8
`endif

// ===== pkg/lpf_pkg.sv
// Types shared by the land pre-pit block framer.
package lpf_pkg;
    typedef enum logic [1:0] {
        lpf_st_idle = 2'b01,
        lpf_st_run  = 2'b10
    } lpf_state_t;
    typedef logic [2:0] lpf_sym_t;
    typedef logic [3:0] lpf_nib_t;
endpackage : lpf_pkg

// ===== rtl/lpf_framer.sv
// Land pre-pit framer: byte FIFO and the symbol stream generator on the groove timebase.
`timescale 1ns/1ps
`include "lpf_cfg.svh"

// Small flip-flop FIFO that decouples the byte supplier from the fixed symbol timebase.
// Ready is registered so the filling side sees a clean level; the price is that a slot
// freed by a pop is offered one cycle later. Valid is registered as well, so the read
// side sees a byte only a cycle after it was written, never in the same cycle.
module lpf_fifo #(
    parameter int WIDTH = `LPF_BYTE_W,
    parameter int DEPTH = `LPF_FIFO_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             ready;
    logic             valid;

    wire logic        push = in_valid_i && ready;
    wire logic        pop  = out_ready_i && valid;
    wire logic [AW:0] next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);

    // Flag outputs come straight from their registers.
    assign in_ready_o  = ready;
    assign out_valid_o = valid;
    assign out_data_o  = mem[rd_ptr];

    // Storage is written only on an accepted push.
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH, so depths that are not a power of two work too.
    // The count is kept beside the pointers, which makes full and empty plain compares.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            ready  <= 1'b1;
            valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + AW'(1);
            end
            count <= next_count;
            ready <= (next_count != FULL_CNT);
            valid <= (next_count != '0);
        end
    end
endmodule : lpf_fifo

// Symbol stream generator; one symbol set leaves per pair of groove sync frames.
// The groove side supplies a single-cycle tick per sync frame; ticks alternate between
// the even and the odd half of each pair, the first tick after start being even.
// Part one address bytes come from an internal counter; the parity of part one and all
// part two bytes come from the FIFO in the order in which they are to be sent.
// The framer never stalls the timebase: a byte that is missing is sent as zero.
module lpf_framer #(
    parameter logic [23:0] FIRST_ADDR = `LPF_FIRST_ADDR,
    parameter int          FIFO_DEPTH = `LPF_FIFO_DEPTH
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     enable_i,
    input  wire logic                     sync_frame_i,
    input  wire logic                     neighbour_pit_i,
    input  wire logic                     addr_load_i,
    input  wire logic [23:0]              addr_i,
    input  wire logic [`LPF_BYTE_W-1:0]   data_i,
    input  wire logic                     data_valid_i,
    output logic                          data_ready_o,
    output lpf_pkg::lpf_sym_t             sym_o,
    output logic                          sym_valid_o,
    output logic                          slot_odd_o,
    output logic                          sector_start_o,
    output logic                          block_start_o,
    output lpf_pkg::lpf_nib_t             frame_addr_o,
    output logic [23:0]                   track_addr_o,
    output logic                          underrun_o,
    output logic                          busy_o
);
    import lpf_pkg::*;

    lpf_state_t             state;
    logic                   pair_ph;
    logic                   odd_pend;
    lpf_nib_t               sym_idx;
    lpf_nib_t               frame;
    logic [11:0]            shreg;
    logic [23:0]            addr;
    logic [`LPF_BYTE_W-1:0] fifo_data;
    logic                   fifo_valid;
    logic                   fifo_ready;

    // Byte source: part one address bytes come from the address counter, the rest from software.
    // Only frames 0 to 2 reach this decode; every later frame takes its byte from the FIFO.
    function automatic logic [7:0] addr_byte(input lpf_nib_t f, input logic [23:0] a);
        logic [7:0] b;
        b = 8'h00;
        unique case (f[1:0])
            2'b00:   b = a[23:16];
            2'b01:   b = a[15:8];
            default: b = a[7:0];
        endcase
        return b;
    endfunction : addr_byte

    // Byte queue between the supplier and the framer.
    lpf_fifo #(
        .WIDTH (`LPF_BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_data_i   (data_i),
        .in_valid_i  (data_valid_i),
        .in_ready_o  (data_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready)
    );

    // Slot timing: the pair phase splits each two-frame interval into even and odd halves.
    // An even tick with a pit on the neighbouring land is not used; the set waits for the
    // odd tick of the same pair, so the rate of one set per pair is kept either way.
    wire logic running   = (state == lpf_st_run);
    wire logic even_tick = running && sync_frame_i && !pair_ph;
    wire logic odd_tick  = running && sync_frame_i && pair_ph;
    wire logic emit_even = even_tick && !neighbour_pit_i;
    wire logic emit_odd  = odd_tick && odd_pend;
    wire logic emit      = emit_even || emit_odd;

    // Sector position decode; set 0 is the sync code, sets 1 to 12 carry the frame bits.
    // The block ends with the last set of frame 15, which is also where the address steps.
    wire logic at_sync   = (sym_idx == 4'h0);
    wire logic last_sym  = (sym_idx == `LPF_LAST_SYM);
    wire logic last_frm  = (frame == `LPF_LAST_FRAME);
    wire logic end_block = emit && last_sym && last_frm;
    wire logic need_fifo = (frame >= `LPF_FIRST_FIFO);

    // A missing byte is sent as zero; the timebase cannot wait for software.
    // The FIFO is popped only at the sync set of a frame that needs it, so a byte that
    // arrives late waits for the next such frame and the byte order slips by one; the
    // underrun strobe tells the supplier that this has happened.
    wire logic       load     = emit && at_sync;
    wire logic       starve   = load && need_fifo && !fifo_valid;
    wire logic [7:0] cur_byte = need_fifo ? (fifo_valid ? fifo_data : 8'h00)
                                          : addr_byte(frame, addr);
    assign fifo_ready = load && need_fifo;

    // Symbol choice: sync code at slot zero, transformed bits afterwards.
    // The shifter holds the frame most significant bit first, so bit 11 is always next.
    wire lpf_sym_t sync_sym = emit_odd ? `LPF_SYNC_ODD : `LPF_SYNC_EVEN;
    wire lpf_sym_t data_sym = shreg[11] ? `LPF_BIT_ONE : `LPF_BIT_ZERO;
    wire lpf_sym_t next_sym = at_sync ? sync_sym : data_sym;

    // Control state; a running block always finishes before the framer stops.
    // Stopping mid-block would leave the reader with a part block that it cannot decode.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= lpf_st_idle;
        end else begin
            unique case (state)
                lpf_st_idle: begin
                    if (enable_i) begin
                        state <= lpf_st_run;
                    end
                end
                lpf_st_run: begin
                    if (end_block && !enable_i) begin
                        state <= lpf_st_idle;
                    end
                end
            endcase
        end
    end

    // Pair phase and the deferred odd slot.
    // Both are cleared while idle, so every start begins on an even half.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pair_ph  <= 1'b0;
            odd_pend <= 1'b0;
        end else if (!running) begin
            pair_ph  <= 1'b0;
            odd_pend <= 1'b0;
        end else if (sync_frame_i) begin
            pair_ph  <= !pair_ph;
            odd_pend <= even_tick && neighbour_pit_i;
        end
    end

    // Position counters: 13 sets per sector, 16 sectors per block, address order.
    // The frame counter wraps from 15 to 0, which opens the next block.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sym_idx <= 4'h0;
            frame   <= 4'h0;
        end else if (!running) begin
            sym_idx <= 4'h0;
            frame   <= 4'h0;
        end else if (emit) begin
            sym_idx <= last_sym ? 4'h0 : sym_idx + 4'h1;
            if (last_sym) begin
                frame <= frame + 4'h1;
            end
        end
    end

    // Frame shifter: relative address then byte, most significant bit first.
    // It loads on the sync set and shifts once per data set, after that set used bit 11.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shreg <= 12'h000;
        end else if (load) begin
            shreg <= {frame, cur_byte};
        end else if (emit) begin
            shreg <= {shreg[10:0], 1'b0};
        end
    end

    // Track address counts down once per finished block.
    // A load wins over the count, so a seek lands exactly on the loaded value.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr <= FIRST_ADDR;
        end else if (addr_load_i) begin
            addr <= addr_i;
        end else if (end_block) begin
            addr <= addr - 24'h000001;
        end
    end

    // Output strobes; each but busy_o, which is a level, is a single-cycle pulse that marks a symbol, a sector, a block or an underrun.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sym_valid_o    <= 1'b0;
            sector_start_o <= 1'b0;
            block_start_o  <= 1'b0;
            underrun_o     <= 1'b0;
            busy_o         <= 1'b0;
        end else begin
            sym_valid_o    <= emit;
            sector_start_o <= load;
            block_start_o  <= load && (frame == 4'h0);
            underrun_o     <= starve;
            busy_o         <= running;
        end
    end

    // Held outputs change only with a new symbol, so a slow reader may sample them late.
    // Track address shows the value in use for that symbol, not the counter's next value.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sym_o        <= 3'h0;
            slot_odd_o   <= 1'b0;
            frame_addr_o <= 4'h0;
            track_addr_o <= FIRST_ADDR;
        end else if (emit) begin
            sym_o        <= next_sym;
            slot_odd_o   <= emit_odd;
            frame_addr_o <= frame;
            track_addr_o <= addr;
        end
    end
endmodule : lpf_framer

// ===== verif/lpf_framer_properties.sv
// Concurrent checks on the framer output stream.
`timescale 1ns/1ps
module lpf_framer_chk (
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              sync_frame_i,
    input wire lpf_pkg::lpf_sym_t sym_o,
    input wire logic              sym_valid_o,
    input wire logic              slot_odd_o,
    input wire logic              sector_start_o,
    input wire logic              block_start_o,
    input wire lpf_pkg::lpf_nib_t frame_addr_o,
    input wire logic              underrun_o
);
    import lpf_pkg::*;
    logic [3:0] sym_cnt;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Counts sets since the last sync code so sector length is visible.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sym_cnt <= 4'h0;
        end else if (sym_valid_o) begin
            sym_cnt <= sector_start_o ? 4'h1 : sym_cnt + 4'h1;
        end
    end
    sym_tick_a: assert property (sym_valid_o |-> $past(sync_frame_i))
        else $error("symbol without groove tick");
    one_strobe_a: assert property (sym_valid_o |=> !sym_valid_o)
        else $error("symbol strobe too long");
    sync_open_a: assert property (sector_start_o |-> sym_valid_o && sym_o[2:1] == 2'h3)
        else $error("sector not opened by sync code");
    sync_slot_a: assert property (sector_start_o |-> sym_o[0] == !slot_odd_o)
        else $error("sync code disagrees with slot");
    data_code_a: assert property (sym_valid_o && !sector_start_o |-> sym_o[2:1] == 2'h2)
        else $error("bad data symbol");
    block_zero_a: assert property (block_start_o |-> sector_start_o && frame_addr_o == 4'h0)
        else $error("block start off frame zero");
    frame_step_a: assert property (sector_start_o && !block_start_o |->
        frame_addr_o == $past(frame_addr_o) + 4'h1)
        else $error("frame address skipped");
    sector_len_a: assert property (sym_valid_o |->
        sector_start_o == (sym_cnt == 4'hd || sym_cnt == 4'h0))
        else $error("sector length wrong");
    underrun_pos_a: assert property (underrun_o |-> sector_start_o && frame_addr_o >= 4'h3)
        else $error("underrun outside data frames");
endmodule : lpf_framer_chk

// ===== verif/lpf_rx_model.sv
// Read channel model that decodes the pre-pit symbol stream into frames.
`timescale 1ns/1ps
module lpf_rx_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [2:0]  sym_i,
    input  wire logic        sym_valid_i,
    output logic             frame_done_o,
    output logic [11:0]      frame_o,
    output logic             odd_o,
    output logic             bad_o
);
    logic [3:0] cnt;
    // The slot is read from the sync set only, so a slot change inside a sector is not followed.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 4'h0;
            frame_o <= 12'h000;
            odd_o <= 1'b0;
            bad_o <= 1'b0;
            frame_done_o <= 1'b0;
        end else begin
            frame_done_o <= 1'b0;
            if (sym_valid_i) begin
                bad_o <= bad_o | !sym_i[2];
                if (sym_i[1]) begin
                    odd_o <= !sym_i[0];
                    cnt <= 4'h0;
                end else begin
                    frame_o <= {frame_o[10:0], sym_i[0]};
                    cnt <= cnt + 4'h1;
                    frame_done_o <= (cnt == 4'hb);
                end
            end
        end
    end
endmodule : lpf_rx_model

// ===== verif/lpf_framer_tb.sv
// Self-checking bench for the pre-pit framer.
`timescale 1ns/1ps
module lpf_framer_tb;
    import lpf_pkg::*;
    logic ref_clk_i = 0, rstn_i = 0, enable_i = 0, sync_frame_i = 0;
    logic neighbour_pit_i = 0, addr_load_i = 0, data_valid_i = 0, taken = 0;
    logic [23:0] addr_i = 24'h000001, exp_addr, track_addr_o;
    logic [7:0] data_i = 8'h00;
    logic data_ready_o, sym_valid_o, slot_odd_o, sector_start_o, block_start_o;
    logic underrun_o, busy_o, f_done, rx_odd, rx_bad, nb1 = 0, nb2 = 0, sync_odd = 0;
    lpf_sym_t sym_o;
    lpf_nib_t frame_addr_o;
    logic [11:0] f_word;
    logic [7:0] feed[$], sent[$];
    int seed = 88046, mismatches = 0, n_checks = 0, cyc = 0;
    int exp_f = 0, nframes = 0, under_n = 0, nsym = 0, nblk = 0;
    lpf_framer dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .enable_i(enable_i),
        .sync_frame_i(sync_frame_i), .neighbour_pit_i(neighbour_pit_i),
        .addr_load_i(addr_load_i), .addr_i(addr_i), .data_i(data_i),
        .data_valid_i(data_valid_i), .data_ready_o(data_ready_o), .sym_o(sym_o),
        .sym_valid_o(sym_valid_o), .slot_odd_o(slot_odd_o), .sector_start_o(sector_start_o),
        .block_start_o(block_start_o), .frame_addr_o(frame_addr_o),
        .track_addr_o(track_addr_o), .underrun_o(underrun_o), .busy_o(busy_o));
    lpf_rx_model u_rx (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sym_i(sym_o),
        .sym_valid_i(sym_valid_o), .frame_done_o(f_done), .frame_o(f_word),
        .odd_o(rx_odd), .bad_o(rx_bad));
    always #4 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic give_verdict();
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Frames 0 to 2 carry the address, later frames the bytes in push order.
    function automatic logic [7:0] exp_byte(input int f);
        if (f < 3) return exp_addr[23-8*f -: 8];
        return sent.size() > 0 ? sent.pop_front() : 8'h00;
    endfunction : exp_byte
    // Old output values are read here, before the edge's own updates land.
    always @(posedge ref_clk_i) begin
        taken <= data_valid_i && data_ready_o;
        if (data_valid_i && data_ready_o) sent.push_back(data_i);
        if (sync_frame_i) begin
            nb2 <= nb1;
            nb1 <= neighbour_pit_i;
        end
    end
    // Checks settled outputs, then drives ticks, neighbour pits and bytes.
    always @(negedge ref_clk_i) begin
        cyc++;
        if (cyc > 12000) begin
            mismatches++;
            give_verdict();
        end
        if (sym_valid_o === 1'b1) begin
            check(slot_odd_o ? nb2 : !nb1, "slot choice");
            if (sector_start_o === 1'b1) sync_odd = slot_odd_o;
            if (block_start_o === 1'b1) begin
                check(track_addr_o === exp_addr, "track address");
                if (nblk > 0) check(nsym == 208, "block length");
                nsym = 0;
                nblk++;
            end
            nsym++;
        end
        if (underrun_o === 1'b1) under_n++;
        if (f_done === 1'b1) begin
            check(f_word[11:8] === exp_f[3:0], "frame order");
            check(f_word[7:0] === exp_byte(exp_f), "frame byte");
            check(rx_odd === sync_odd, "sync slot decode");
            if (exp_f == 15) exp_addr = exp_addr - 24'h1;
            exp_f = (exp_f + 1) % 16;
            nframes++;
        end
        if (taken) void'(feed.pop_front());
        sync_frame_i <= (cyc % 4 == 0);
        neighbour_pit_i <= 1'($random(seed));
        data_valid_i <= feed.size() > 0;
        data_i <= feed.size() > 0 ? feed[0] : 8'h00;
    end
    initial begin
        repeat (16) @(negedge ref_clk_i);
        rstn_i = 1;
        check(track_addr_o === 24'hffcfff && data_ready_o === 1'b1, "reset values");
        addr_load_i = 1;
        @(negedge ref_clk_i);
        addr_load_i = 0;
        exp_addr = 24'h000001;
        feed.push_back(8'hff);
        feed.push_back(8'h00);
        repeat (24) feed.push_back(8'($random(seed)));
        repeat (20) @(negedge ref_clk_i);
        check(data_ready_o === 1'b0 && sent.size() == 8, "fifo not full");
        enable_i = 1;
        while (nframes < 40) @(negedge ref_clk_i);
        enable_i = 0;
        while (busy_o !== 1'b0) @(negedge ref_clk_i);
        repeat (4) @(negedge ref_clk_i);
        check(nframes == 48 && nblk == 3, "stop off block end");
        check(under_n == 13 && sent.size() == 0, "underrun count");
        check(rx_bad === 1'b0 && data_ready_o === 1'b1, "stream damage");
        give_verdict();
    end
endmodule : lpf_framer_tb
bind lpf_framer lpf_framer_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .sync_frame_i(sync_frame_i), .sym_o(sym_o), .sym_valid_o(sym_valid_o),
    .slot_odd_o(slot_odd_o), .sector_start_o(sector_start_o),
    .block_start_o(block_start_o), .frame_addr_o(frame_addr_o), .underrun_o(underrun_o));
